// File: shared/dctp_defs.vh
// Constants for the dual counter/timer block with shared prescaler.
// Included by the register/timer core and the prescaler module.
`ifndef DCTP_DEFS_VH
`define DCTP_DEFS_VH

// Register addresses on the special-register port
`define DCTP_ADDR_CLK_SEL   8'h8E
`define DCTP_ADDR_RUN_FLAGS 8'h88
`define DCTP_ADDR_MODE_CFG  8'h89
`define DCTP_ADDR_CNT0_LO   8'h8A
`define DCTP_ADDR_CNT1_LO   8'h8B
`define DCTP_ADDR_CNT0_HI   8'h8C
`define DCTP_ADDR_CNT1_HI   8'h8D

// Clock-select register fields and writable mask
`define DCTP_CKS_MASK       8'h7B
`define DCTP_CKS_RESET      8'h00
`define DCTP_CKS_T2H_BIT    6
`define DCTP_CKS_T2L_BIT    5
`define DCTP_CKS_T1_BIT     4
`define DCTP_CKS_T0_BIT     3

// Run/flag register bits
`define DCTP_RF_TF1         7
`define DCTP_RF_TR1         6
`define DCTP_RF_TF0         5
`define DCTP_RF_TR0         4

// Mode register fields (per timer nibble)
`define DCTP_MD_GATE        3
`define DCTP_MD_CSEL        2

// Mode encodings
`define DCTP_MODE_13        2'h0
`define DCTP_MODE_16        2'h1
`define DCTP_MODE_RELOAD    2'h2
`define DCTP_MODE_SPLIT     2'h3

// Prescale codes and divide counts
`define DCTP_PS_DIV12       2'h0
`define DCTP_PS_DIV4        2'h1
`define DCTP_PS_DIV48       2'h2
`define DCTP_PS_EXT8        2'h3
`define DCTP_DIV12_LAST     6'h0B
`define DCTP_DIV4_LAST      6'h03
`define DCTP_DIV48_LAST     6'h2F
`define DCTP_EXT8_LAST      3'h7

`define DCTP_BYTE_ONES      8'hFF
`define DCTP_LOW5_ONES      5'h1F

`endif

// File: logic/dctp_prescaler.v
// Shared prescaler: one-cycle tick at the selected divided rate.
// Assumes ext_clk_sync already passed the caller's two-flop synchroniser.
`timescale 1ns/10ps
`default_nettype none
`include "dctp_defs.vh"

module dctp_prescaler (
  input  wire       clk_sys,
  input  wire       nrst,
  input  wire [1:0] prescale_code,
  input  wire       ext_clk_sync,
  output reg        tick_r
);

  reg  [5:0] div_cnt_r;
  reg  [2:0] ext_cnt_r;
  reg        ext_prev_r;
  reg  [5:0] last_val;
  wire       ext_rise;

  assign ext_rise = ext_clk_sync & ~ext_prev_r;

  always @* begin
    case (prescale_code)
      `DCTP_PS_DIV12: last_val = `DCTP_DIV12_LAST;
      `DCTP_PS_DIV4:  last_val = `DCTP_DIV4_LAST;
      `DCTP_PS_DIV48: last_val = `DCTP_DIV48_LAST;
      default:        last_val = `DCTP_DIV12_LAST;
    endcase
  end

  always @(posedge clk_sys) begin
    if (!nrst) begin
      div_cnt_r  <= 6'h00;
      ext_cnt_r  <= 3'h0;
      ext_prev_r <= 1'b0;
      tick_r     <= 1'b0;
    end else begin
      ext_prev_r <= ext_clk_sync;
      if (prescale_code == `DCTP_PS_EXT8) begin
        div_cnt_r <= 6'h00;
        if (ext_rise) begin
          ext_cnt_r <= ext_cnt_r + 3'h1;
        end
        tick_r <= ext_rise && (ext_cnt_r == `DCTP_EXT8_LAST);
      end else begin
        ext_cnt_r <= 3'h0;
        if (div_cnt_r >= last_val) begin
          div_cnt_r <= 6'h00;
          tick_r    <= 1'b1;
        end else begin
          div_cnt_r <= div_cnt_r + 6'h01;
          tick_r    <= 1'b0;
        end
      end
    end
  end

endmodule // dctp_prescaler

`default_nettype wire

// File: logic/dctp_timers.v
// Two counter/timers with their clock-select, run/flag and mode registers.
// Assumes a one-cycle register port on clk_sys; pins are asynchronous.
`timescale 1ns/10ps
`default_nettype none
`include "dctp_defs.vh"

module dctp_timers (
  input  wire       clk_sys,
  input  wire       nrst,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  output reg  [7:0] reg_rdata_r,
  input  wire       first_count_pin,
  input  wire       second_count_pin,
  input  wire       first_gate_input,
  input  wire       second_gate_input,
  input  wire       first_gate_polarity,
  input  wire       second_gate_polarity,
  input  wire       ext_prescale_clk,
  input  wire       first_irq_enable,
  input  wire       second_irq_enable,
  input  wire       first_irq_ack,
  input  wire       second_irq_ack,
  output reg        first_irq_req_r,
  output reg        second_irq_req_r,
  output reg        second_overflow_pulse_r,
  output reg        third_timer_high_clk_sel_r,
  output reg        third_timer_low_clk_sel_r
);

  // Byte increment with carry
  function [8:0] dctp_inc8;
    input [7:0] v;
    begin
      dctp_inc8 = {1'b0, v} + 9'h001;
    end
  endfunction

  reg  [7:0] timer_clock_select_r;
  reg  [7:0] timer_run_flags_r;
  reg  [7:0] timer_mode_config_r;
  reg  [7:0] first_count_low_r;
  reg  [7:0] first_count_high_r;
  reg  [7:0] second_count_low_r;
  reg  [7:0] second_count_high_r;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and falling-edge detect
  reg  [1:0] pin0_sync_r;
  reg  [1:0] pin1_sync_r;
  reg  [1:0] first_gate_bit_sync_r;
  reg  [1:0] second_gate_bit_sync_r;
  reg  [1:0] ext_sync_r;
  reg        pin0_prev_r;
  reg        pin1_prev_r;
  wire       pin0_fall;
  wire       pin1_fall;
  wire       presc_tick;

  always @(posedge clk_sys) begin
    if (!nrst) begin
      pin0_sync_r  <= 2'h3;
      pin1_sync_r  <= 2'h3;
      first_gate_bit_sync_r <= 2'h0;
      second_gate_bit_sync_r <= 2'h0;
      ext_sync_r   <= 2'h0;
      pin0_prev_r  <= 1'b1;
      pin1_prev_r  <= 1'b1;
    end else begin
      pin0_sync_r  <= {pin0_sync_r[0], first_count_pin};
      pin1_sync_r  <= {pin1_sync_r[0], second_count_pin};
      first_gate_bit_sync_r <= {first_gate_bit_sync_r[0], first_gate_input};
      second_gate_bit_sync_r <= {second_gate_bit_sync_r[0], second_gate_input};
      ext_sync_r   <= {ext_sync_r[0], ext_prescale_clk};
      pin0_prev_r  <= pin0_sync_r[1];
      pin1_prev_r  <= pin1_sync_r[1];
    end
  end

  assign pin0_fall = pin0_prev_r & ~pin0_sync_r[1];
  assign pin1_fall = pin1_prev_r & ~pin1_sync_r[1];

  dctp_prescaler u_presc (
    .clk_sys       (clk_sys),
    .nrst          (nrst),
    .prescale_code (timer_clock_select_r[1:0]),
    .ext_clk_sync  (ext_sync_r[1]),
    .tick_r        (presc_tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // Count enables
  wire [1:0] mode0 = timer_mode_config_r[1:0];
  wire [1:0] mode1 = timer_mode_config_r[5:4];
  wire       split = (mode0 == `DCTP_MODE_SPLIT);
  wire       tr0   = timer_run_flags_r[`DCTP_RF_TR0];
  wire       tr1   = timer_run_flags_r[`DCTP_RF_TR1];
  wire       first_gate_bit = timer_mode_config_r[`DCTP_MD_GATE];
  wire       second_gate_bit = timer_mode_config_r[4 + `DCTP_MD_GATE];
  wire       cs0   = timer_mode_config_r[`DCTP_MD_CSEL];
  wire       cs1   = timer_mode_config_r[4 + `DCTP_MD_CSEL];
  wire       gact0 = first_gate_bit_sync_r[1] ~^ first_gate_polarity;
  wire       gact1 = second_gate_bit_sync_r[1] ~^ second_gate_polarity;
  wire       tclk0 = timer_clock_select_r[`DCTP_CKS_T0_BIT] ? 1'b1 : presc_tick;
  wire       tclk1 = timer_clock_select_r[`DCTP_CKS_T1_BIT] ? 1'b1 : presc_tick;
  wire       src0  = cs0 ? pin0_fall : tclk0;
  // In split mode the second timer may not count its pin
  wire       src1  = (cs1 && !split) ? pin1_fall : tclk1;
  wire       inc0  = tr0 && (!first_gate_bit || gact0) && src0;
  wire       run1  = split ? (mode1 != `DCTP_MODE_SPLIT) : (tr1 && (!second_gate_bit || gact1));
  wire       inc1  = run1 && (mode1 != `DCTP_MODE_SPLIT) && src1;
  wire       inc0h = split && tr1 && tclk0;

  ////////////////////////////////////////////////////////////////////////
  // Counter next values
  reg  [7:0] lo0_nxt;
  reg  [7:0] hi0_nxt;
  reg        ovf0;
  reg        ovf0h;
  reg  [7:0] lo1_nxt;
  reg  [7:0] hi1_nxt;
  reg        ovf1;
  reg  [8:0] s_lo;
  reg  [8:0] s_hi;
  reg  [8:0] s_lo1;
  reg  [8:0] s_hi1;

  always @* begin
    lo0_nxt = first_count_low_r;
    hi0_nxt = first_count_high_r;
    ovf0    = 1'b0;
    ovf0h   = 1'b0;
    s_lo    = dctp_inc8(first_count_low_r);
    s_hi    = dctp_inc8(first_count_high_r);
    if (inc0) begin
      case (mode0)
        `DCTP_MODE_13: begin
          if (first_count_low_r[4:0] == `DCTP_LOW5_ONES) begin
            lo0_nxt = {first_count_low_r[7:5], 5'h00};
            hi0_nxt = s_hi[7:0];
            ovf0    = s_hi[8];
          end else begin
            lo0_nxt = s_lo[7:0];
          end
        end
        `DCTP_MODE_16: begin
          lo0_nxt = s_lo[7:0];
          if (s_lo[8]) begin
            hi0_nxt = s_hi[7:0];
            ovf0    = s_hi[8];
          end
        end
        `DCTP_MODE_RELOAD: begin
          lo0_nxt = s_lo[8] ? first_count_high_r : s_lo[7:0];
          ovf0    = s_lo[8];
        end
        default: begin
          lo0_nxt = s_lo[7:0];
          ovf0    = s_lo[8];
        end
      endcase
    end
    if (inc0h) begin
      hi0_nxt = s_hi[7:0];
      ovf0h   = s_hi[8];
    end
  end

  always @* begin
    lo1_nxt = second_count_low_r;
    hi1_nxt = second_count_high_r;
    ovf1    = 1'b0;
    s_lo1   = dctp_inc8(second_count_low_r);
    s_hi1   = dctp_inc8(second_count_high_r);
    if (inc1) begin
      case (mode1)
        `DCTP_MODE_13: begin
          if (second_count_low_r[4:0] == `DCTP_LOW5_ONES) begin
            lo1_nxt = {second_count_low_r[7:5], 5'h00};
            hi1_nxt = s_hi1[7:0];
            ovf1    = s_hi1[8];
          end else begin
            lo1_nxt = s_lo1[7:0];
          end
        end
        `DCTP_MODE_16: begin
          lo1_nxt = s_lo1[7:0];
          if (s_lo1[8]) begin
            hi1_nxt = s_hi1[7:0];
            ovf1    = s_hi1[8];
          end
        end
        `DCTP_MODE_RELOAD: begin
          lo1_nxt = s_lo1[8] ? second_count_high_r : s_lo1[7:0];
          ovf1    = s_lo1[8];
        end
        default: begin
          ovf1 = 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register writes; hardware counting and flag set win over writes
  wire wr_cks = reg_wr && (reg_addr == `DCTP_ADDR_CLK_SEL);
  wire wr_rf  = reg_wr && (reg_addr == `DCTP_ADDR_RUN_FLAGS);
  wire wr_md  = reg_wr && (reg_addr == `DCTP_ADDR_MODE_CFG);
  wire set_f0 = ovf0;
  wire set_f1 = split ? ovf0h : ovf1;

  always @(posedge clk_sys) begin
    if (!nrst) begin
      timer_clock_select_r    <= `DCTP_CKS_RESET;
      timer_run_flags_r       <= 8'h00;
      timer_mode_config_r     <= 8'h00;
      first_count_low_r       <= 8'h00;
      first_count_high_r      <= 8'h00;
      second_count_low_r      <= 8'h00;
      second_count_high_r     <= 8'h00;
      second_overflow_pulse_r <= 1'b0;
    end else begin
      if (wr_cks) begin
        timer_clock_select_r <= reg_wdata & `DCTP_CKS_MASK;
      end
      if (wr_md) begin
        timer_mode_config_r <= reg_wdata;
      end
      // Run bits never touch the count
      if (wr_rf) begin
        timer_run_flags_r <= reg_wdata;
      end
      if (first_irq_ack) begin
        timer_run_flags_r[`DCTP_RF_TF0] <= 1'b0;
      end
      if (second_irq_ack) begin
        timer_run_flags_r[`DCTP_RF_TF1] <= 1'b0;
      end
      if (set_f0) begin
        timer_run_flags_r[`DCTP_RF_TF0] <= 1'b1;
      end
      if (set_f1) begin
        timer_run_flags_r[`DCTP_RF_TF1] <= 1'b1;
      end
      first_count_low_r   <= (reg_wr && reg_addr == `DCTP_ADDR_CNT0_LO && !inc0)
                             ? reg_wdata : lo0_nxt;
      first_count_high_r  <= (reg_wr && reg_addr == `DCTP_ADDR_CNT0_HI && !inc0 && !inc0h)
                             ? reg_wdata : hi0_nxt;
      second_count_low_r  <= (reg_wr && reg_addr == `DCTP_ADDR_CNT1_LO && !inc1)
                             ? reg_wdata : lo1_nxt;
      second_count_high_r <= (reg_wr && reg_addr == `DCTP_ADDR_CNT1_HI && !inc1)
                             ? reg_wdata : hi1_nxt;
      second_overflow_pulse_r <= ovf1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data, interrupt requests and third-timer selects
  always @(posedge clk_sys) begin
    if (!nrst) begin
      reg_rdata_r                <= 8'h00;
      first_irq_req_r            <= 1'b0;
      second_irq_req_r           <= 1'b0;
      third_timer_high_clk_sel_r <= 1'b0;
      third_timer_low_clk_sel_r  <= 1'b0;
    end else begin
      case (reg_addr)
        `DCTP_ADDR_CLK_SEL:   reg_rdata_r <= timer_clock_select_r;
        `DCTP_ADDR_RUN_FLAGS: reg_rdata_r <= timer_run_flags_r;
        `DCTP_ADDR_MODE_CFG:  reg_rdata_r <= timer_mode_config_r;
        `DCTP_ADDR_CNT0_LO:   reg_rdata_r <= first_count_low_r;
        `DCTP_ADDR_CNT1_LO:   reg_rdata_r <= second_count_low_r;
        `DCTP_ADDR_CNT0_HI:   reg_rdata_r <= first_count_high_r;
        `DCTP_ADDR_CNT1_HI:   reg_rdata_r <= second_count_high_r;
        default:              reg_rdata_r <= 8'h00;
      endcase
      first_irq_req_r  <= timer_run_flags_r[`DCTP_RF_TF0] & first_irq_enable;
      second_irq_req_r <= timer_run_flags_r[`DCTP_RF_TF1] & second_irq_enable;
      third_timer_high_clk_sel_r <= timer_clock_select_r[`DCTP_CKS_T2H_BIT];
      third_timer_low_clk_sel_r  <= timer_clock_select_r[`DCTP_CKS_T2L_BIT];
    end
  end

endmodule // dctp_timers

`default_nettype wire

// File: sim/dctp_timers_sva.sv
// Checker for the register read port and interrupt request outputs.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module dctp_timers_sva (
  input wire logic       clk_sys,
  input wire logic       nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_rdata_r,
  input wire logic       first_irq_enable,
  input wire logic       second_irq_enable,
  input wire logic       first_irq_ack,
  input wire logic       first_irq_req_r,
  input wire logic       second_irq_req_r,
  input wire logic       third_timer_high_clk_sel_r,
  input wire logic       third_timer_low_clk_sel_r
);
  wire wr_ck = reg_wr && reg_addr == 8'h8E;
  wire wr_rf = reg_wr && reg_addr == 8'h88;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////
  chk_rd_unused: assert property (
    $past(reg_addr) == 8'h8E |-> reg_rdata_r[7] == 1'b0 && reg_rdata_r[2] == 1'b0)
    else $error("unused clock select bits read nonzero");
  chk_rd_unmapped: assert property (
    $past(reg_addr) < 8'h88 || $past(reg_addr) > 8'h8E |-> reg_rdata_r == 8'h00)
    else $error("unmapped address read nonzero");
  chk_irq1_enable: assert property (
    !$past(first_irq_enable) |-> !first_irq_req_r)
    else $error("first request without enable");
  chk_irq2_enable: assert property (
    !$past(second_irq_enable) |-> !second_irq_req_r)
    else $error("second request without enable");
  chk_irq1_holds: assert property (
    first_irq_req_r && first_irq_enable && !first_irq_ack && !$past(first_irq_ack)
    && !wr_rf && !$past(wr_rf) |=> first_irq_req_r)
    else $error("first request dropped without clear");
  chk_high_sel_copy: assert property (
    wr_ck |-> ##2 third_timer_high_clk_sel_r == $past(reg_wdata[6], 2))
    else $error("high byte clock select not stored");
  chk_low_sel_copy: assert property (
    wr_ck |-> ##2 third_timer_low_clk_sel_r == $past(reg_wdata[5], 2))
    else $error("low byte clock select not stored");
  chk_high_sel_stable: assert property (
    $changed(third_timer_high_clk_sel_r) |-> $past(wr_ck) || $past(wr_ck, 2))
    else $error("high byte clock select changed without write");
endmodule // dctp_timers_sva
bind dctp_timers dctp_timers_sva i_dctp_timers_sva (.clk_sys, .nrst, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rdata_r, .first_irq_enable, .second_irq_enable,
  .first_irq_ack, .first_irq_req_r, .second_irq_req_r, .third_timer_high_clk_sel_r,
  .third_timer_low_clk_sel_r);
`default_nettype wire

// File: sim/dctp_pin_model.sv
// Pin-side model: count pins, gate inputs and a free external clock.
// Assumes the bench calls its tasks; pins idle high, gates idle low.
`timescale 1ns/10ps
`default_nettype none
module dctp_pin_model (
  input  wire logic clk_sys,
  output wire logic first_count_pin,
  output wire logic second_count_pin,
  output wire logic first_gate_input,
  output wire logic second_gate_input,
  output wire logic ext_prescale_clk
);
  logic [1:0] pin_r  = 2'b11;
  logic [1:0] gate_r = 2'b00;
  logic       xclk_r = 1'b0;
  assign first_count_pin   = pin_r[0];
  assign second_count_pin  = pin_r[1];
  assign first_gate_input  = gate_r[0];
  assign second_gate_input = gate_r[1];
  assign ext_prescale_clk  = xclk_r;
  // Oscillator runs free, unrelated to clk_sys
  always #195 xclk_r = ~xclk_r;
  task fall(input integer t, input integer n);
    begin
      repeat (n) begin
        repeat (3) @(posedge clk_sys);
        pin_r[t] <= 1'b0;
        repeat (3) @(posedge clk_sys);
        pin_r[t] <= 1'b1;
      end
    end
  endtask
  task set_gate(input integer t, input logic v);
    gate_r[t] <= v;
  endtask
endmodule // dctp_pin_model
`default_nettype wire

// File: sim/dctp_timers_tb.sv
// Self-checking bench for the dual counter/timer block.
// Assumes the pin model drives the asynchronous pins and external clock.
`timescale 1ns/10ps
`default_nettype none
module dctp_timers_tb;
  logic       clk_sys = 1'b0;
  logic       nrst = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       first_gate_polarity = 1'b1;
  logic       second_gate_polarity = 1'b1;
  logic       first_irq_enable = 1'b0;
  logic       second_irq_enable = 1'b0;
  logic       first_irq_ack = 1'b0;
  logic       second_irq_ack = 1'b0;
  wire  [7:0] reg_rdata_r;
  wire        first_count_pin, second_count_pin, first_gate_input, second_gate_input;
  wire        ext_prescale_clk, first_irq_req_r, second_irq_req_r;
  wire        second_overflow_pulse_r, third_timer_high_clk_sel_r, third_timer_low_clk_sel_r;
  logic [7:0] rv;
  logic [7:0] cks_val [5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h10};
  logic [7:0] cnt_exp [5] = '{8'd8, 8'd24, 8'd2, 8'd3, 8'd98};
  integer     error_cnt = 0;
  integer     tests_run = 0;
  integer     i;
  always #50 clk_sys = ~clk_sys;
  dctp_timers i_dctp_timers (.*);
  dctp_pin_model i_dctp_pin_model (.*);
  ////////////////////////////////////////////////////////////////////////////
  task chk(input [15:0] seen, input [15:0] exp, input [79:0] what);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("ERROR %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task final_report;
    begin
      $display("checks %0d errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk_sys);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(posedge clk_sys);
      reg_addr <= a;
      @(posedge clk_sys);
      #1 rv = reg_rdata_r;
    end
  endtask
  task wait_req(input logic w, input integer lim);
    integer k;
    begin
      k = 0;
      while ((w ? second_irq_req_r : first_irq_req_r) !== 1'b1 && k < lim) begin
        @(posedge clk_sys);
        k = k + 1;
      end
      chk(k < lim, 1, "irq_req");
      if (k >= lim) final_report;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    for (i = 8'h88; i <= 8'h8E; i = i + 1) begin
      rd(i[7:0]);
      chk(rv, 8'h00, "reset_val");
    end
    wr(8'h8F, 8'h55);
    rd(8'h8F);
    chk(rv, 8'h00, "unmapped");
    wr(8'h8E, 8'hFF);
    rd(8'h8E);
    chk(rv, 8'h7B, "clk_sel");
    chk({third_timer_high_clk_sel_r, third_timer_low_clk_sel_r}, 2'b11, "t2_sel");
    for (i = 0; i < 5; i = i + 1) begin
      wr(8'h8E, cks_val[i]);
      wr(8'h89, 8'h10);
      wr(8'h8B, 8'h00);
      wr(8'h8D, 8'h00);
      wr(8'h88, 8'h40);
      repeat (96) @(posedge clk_sys);
      wr(8'h88, 8'h00);
      rd(8'h8B);
      chk(rv + 8'd1 - cnt_exp[i] <= 8'd2, 1, "prescale");
    end
    @(posedge clk_sys);
    first_irq_enable  <= 1'b1;
    second_irq_enable <= 1'b1;
    wr(8'h8E, 8'h08);
    wr(8'h8A, 8'hFE);
    wr(8'h8C, 8'hFF);
    wr(8'h89, 8'h01);
    wr(8'h88, 8'h10);
    wait_req(1'b0, 20);
    wr(8'h88, 8'h00);
    rd(8'h88);
    chk(rv, 8'h00, "flag_clr");
    chk(first_irq_req_r, 1'b0, "req_clr");
    wr(8'h8C, 8'hFF);
    wr(8'h8A, 8'h1E);
    wr(8'h89, 8'h00);
    wr(8'h88, 8'h10);
    wait_req(1'b0, 20);
    @(posedge clk_sys);
    first_irq_ack <= 1'b1;
    @(posedge clk_sys);
    first_irq_ack <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 chk(first_irq_req_r, 1'b0, "ack_clr");
    wr(8'h88, 8'h00);
    rd(8'h8C);
    chk(rv, 8'h00, "wrap13");
    wr(8'h89, 8'h09);
    wr(8'h8A, 8'h10);
    wr(8'h8C, 8'h00);
    wr(8'h88, 8'h10);
    repeat (20) @(posedge clk_sys);
    rd(8'h8A);
    chk(rv, 8'h10, "gate_off");
    i_dctp_pin_model.set_gate(0, 1'b1);
    repeat (20) @(posedge clk_sys);
    rd(8'h8A);
    chk(rv > 8'h10, 1, "gate_on");
    for (i = 0; i < 2; i = i + 1) begin
      wr(8'h89, i ? 8'h50 : 8'h05);
      wr(8'h8A + i[7:0], 8'h00);
      wr(8'h8C + i[7:0], 8'h00);
      wr(8'h88, i ? 8'h40 : 8'h10);
      i_dctp_pin_model.fall(i, 5);
      repeat (4) @(posedge clk_sys);
      wr(8'h88, 8'h00);
      rd(8'h8A + i[7:0]);
      chk(rv, 8'h05, "pin_count");
    end
    wr(8'h8E, 8'h10);
    wr(8'h89, 8'h20);
    wr(8'h8D, 8'hF0);
    wr(8'h8B, 8'hFE);
    wr(8'h88, 8'h40);
    i = 0;
    while (second_overflow_pulse_r !== 1'b1 && i < 20) begin
      @(posedge clk_sys);
      i = i + 1;
    end
    chk(i < 20, 1, "ovf_pulse");
    wait_req(1'b1, 20);
    wr(8'h88, 8'h00);
    rd(8'h8D);
    chk(rv, 8'hF0, "reload_hi");
    rd(8'h8B);
    chk(rv[7:4], 4'hF, "reload_lo");
    wr(8'h8E, 8'h19);
    wr(8'h8C, 8'hFE);
    wr(8'h8A, 8'h00);
    wr(8'h89, 8'h03);
    wr(8'h88, 8'h40);
    wait_req(1'b1, 40);
    wr(8'h88, 8'h00);
    rd(8'h8A);
    chk(rv, 8'h00, "split_lo");
    final_report;
  end
endmodule // dctp_timers_tb
`default_nettype wire
